// *** core/tpwm_consts.vh ***
// Constants for the three-phase PWM control register block
`ifndef TPWM_CONSTS_VH
`define TPWM_CONSTS_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TPWM_OFS_PENDING 8'hF3
`define TPWM_OFS_CTRL0 8'hF8
`define TPWM_OFS_TACHO 8'hF9
`define TPWM_OFS_XFER 8'hFA
`define TPWM_OFS_POL 8'hFB
`define TPWM_OFS_OUT 8'hFC
`define TPWM_OFS_IMASK 8'hFD
`define TPWM_OFS_DEAD 8'hFE
`define TPWM_OFS_VECT 8'hFF
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define TPWM_RST_CTRL0 8'h83
`define TPWM_RST_ZERO 8'h00
`define TPWM_RST_DEAD 6'h3F
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TPWM_B_DT_EN 7
`define TPWM_B_TACHO_RUN 6
`define TPWM_B_PWM_RUN 5
`define TPWM_B_TACHO_ZERO 4
`define TPWM_B_PWM_ZERO 3
`define TPWM_B_SHAPE 2
`define TPWM_B_DIR 1
`define TPWM_B_COMPL 0
`define TPWM_B_EMG_IRQ_EN 6
`define TPWM_B_CLR_CAPT 5
`define TPWM_B_CAPT_SRC 4
`define TPWM_B_SOFT_CAPT 3
`define TPWM_B_ONE_SHOT 2
`define TPWM_B_GIE 7
`define TPWM_B_SOFT_XFER 1
`define TPWM_B_XFER_MODE 0
`define TPWM_B_EMG_LEVEL 7
`define TPWM_B_CMP_DIR 6
`define TPWM_B_OUT_EN 7
`define TPWM_B_OUT_SRC 6
`define TPWM_B_EMG_PEND 3
// ---------------------------------------------------------------
// Pending flag positions
// ---------------------------------------------------------------
`define TPWM_P_CMP0 7
`define TPWM_P_CAPT 6
`define TPWM_P_TOVF 5
`define TPWM_P_XFER 4
`define TPWM_P_ZERO 3
`define TPWM_P_U 2
`define TPWM_P_V 1
`define TPWM_P_W 0
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TPWM_DT_CLK_PER_STEP 2
`endif

// *** core/tpwm_sync2.v ***
// Two-stage synchroniser for one asynchronous pin
`timescale 1ns/1ps
module tpwm_sync2
(
  input wire core_clk_i,
  input wire srst_i,
  input wire async_i,
  output wire sync_o
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

// *** core/tpwm_dead_time.v ***
// Dead-time generator for one phase: delays each rising edge of either side
`timescale 1ns/1ps
module tpwm_dead_time
(
  input wire core_clk_i,
  input wire srst_i,
  input wire enable_i,
  input wire [6:0] delay_i,
  input wire ref_i,
  output wire hi_o,
  output wire lo_o
);
  reg ref_reg;
  reg [6:0] cnt_reg;

  // Both sides stay low while the counter runs, so the switches never overlap
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ref_reg <= 1'b0;
      cnt_reg <= 7'h00;
    end
    else if (ref_i != ref_reg)
    begin
      ref_reg <= ref_i;
      cnt_reg <= enable_i ? delay_i : 7'h00;
    end
    else if (!enable_i)
      cnt_reg <= 7'h00;
    else if (cnt_reg != 7'h00)
      cnt_reg <= cnt_reg - 7'h01;
  end

  assign hi_o = ref_reg & (cnt_reg == 7'h00);
  assign lo_o = ~ref_reg & (cnt_reg == 7'h00);
endmodule

// *** core/tpwm_ctrl.v ***
// Control, polarity, output and interrupt-mask logic of a three-phase PWM unit
// Functional notes
// - Dead-time enable 0 stops and bypasses dead-time counter; 1 runs it.
// - Tacho run bit starts tacho counter and prescaler; 0 stops both.
// - One-shot mode: hardware clears tacho run on capture or overflow.
// - PWM run bit starts PWM counter and prescaler; 0 stops both.
// - Zero command bits clear their counter, then self-clear; writing 0 does nothing.
// - Shape select: 0 classical counting, 1 zero-centred up/down counting.
// - Direction flag is read-only hardware status: 1 up, 0 down.
// - Complementary select 0 gives same signal on both; 1 dead-time pair.
// - Emergency enable 0 passes pin through; 1 raises request, pends, drops outputs.
// - Clear-on-capture 1 zeroes tacho counter at each capture.
// - Capture source: tacho edge or software command, which self-clears.
// - Tacho one-shot: counting runs from enable to first capture or overflow.
// - Edge field: 00 none, 01 falling, 10 rising, 11 both.
// - A source interrupts only with its own enable and global enable set.
// - Per-register enables choose which preloads a software transfer copies.
// - Software transfer command in software mode copies preloads, then self-clears.
// - Transfer mode: 0 hardware paced by repetition, 1 software only.
// - Emergency level select: 0 low level acknowledged, 1 high level.
// - Zero-centred mode: U, V, W compare flags only in chosen direction.
// - Each of six phase outputs has its own inversion bit.
// - Output enable 0 floats phases; set only while emergency not pending.
// - Output source picks dead-time signals or the six direct bits.
// - Pending flags set by hardware when enabled; software clears by mask only.
// - Dead-time delay is value times two clocks; resets to all ones.
// - Emergency pending not clearable while pin active; request stays high.
`timescale 1ns/1ps
`include "tpwm_consts.vh"
module tpwm_ctrl
(
  input wire core_clk_i,
  input wire srst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  input wire count_up_i,
  input wire [2:0] phase_ref_i,
  input wire cmp0_hit_i,
  input wire tacho_ovf_i,
  input wire auto_xfer_i,
  input wire pwm_zero_hit_i,
  input wire [2:0] phase_cmp_hit_i,
  input wire tacho_pin_i,
  input wire emerg_pin_i,
  output wire pwm_run_o,
  output wire tacho_run_o,
  output wire pwm_clear_o,
  output wire tacho_clear_o,
  output wire counter_shape_o,
  output wire tacho_capture_o,
  output wire hw_transfer_mode_o,
  output wire [4:0] soft_load_o,
  output wire irq_o,
  output wire emerg_core_o,
  output wire [5:0] phase_out_o,
  output wire [5:0] phase_oe_o
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [7:0] ctrl0_reg;
  reg [7:0] tacho_reg;
  reg [7:0] xfer_reg;
  reg [7:0] pol_reg;
  reg [7:0] out_reg;
  reg [7:0] imask_reg;
  reg [5:0] dead_reg;
  reg [7:0] pend_reg;
  reg emerg_pend_reg;
  reg [7:0] rdata_reg;
  reg tacho_prev_reg;
  reg tacho_clear_reg;
  reg capture_reg;
  reg [4:0] load_reg;
  reg [5:0] phase_reg;
  reg [5:0] oe_reg;

  reg [7:0] ctrl0_next;
  reg [7:0] tacho_next;
  reg [7:0] xfer_next;
  reg [7:0] out_next;
  reg [7:0] pend_next;
  reg emerg_pend_next;
  reg [7:0] rdata_next;

  wire tacho_sync;
  wire emerg_sync;
  wire [2:0] dt_hi;
  wire [2:0] dt_lo;
  wire [5:0] dt_pair;
  wire [5:0] src_data;
  wire [5:0] pol_data;
  wire [7:0] set_vec;
  wire wr_ctrl0;
  wire wr_tacho;
  wire wr_xfer;
  wire wr_out;
  wire wr_pend;
  wire wr_vect;
  wire tacho_rise;
  wire tacho_fall;
  wire hw_capture;
  wire soft_capture;
  wire capture_now;
  wire emerg_active;
  wire emerg_event;
  wire dir_ok;
  wire soft_xfer;
  wire one_shot_stop;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  tpwm_sync2 u_sync_tacho
  (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i(tacho_pin_i),
    .sync_o(tacho_sync)
  );

  tpwm_sync2 u_sync_emerg
  (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i(emerg_pin_i),
    .sync_o(emerg_sync)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign wr_ctrl0 = reg_wr_i && (reg_addr_i == `TPWM_OFS_CTRL0);
  assign wr_tacho = reg_wr_i && (reg_addr_i == `TPWM_OFS_TACHO);
  assign wr_xfer = reg_wr_i && (reg_addr_i == `TPWM_OFS_XFER);
  assign wr_out = reg_wr_i && (reg_addr_i == `TPWM_OFS_OUT);
  assign wr_pend = reg_wr_i && (reg_addr_i == `TPWM_OFS_PENDING);
  assign wr_vect = reg_wr_i && (reg_addr_i == `TPWM_OFS_VECT);

  // ---------------------------------------------------------------
  // Tacho capture and emergency
  // ---------------------------------------------------------------
  assign tacho_rise = tacho_sync & ~tacho_prev_reg;
  assign tacho_fall = ~tacho_sync & tacho_prev_reg;
  assign hw_capture = ~tacho_reg[`TPWM_B_CAPT_SRC] &
    ((tacho_reg[0] & tacho_fall) | (tacho_reg[1] & tacho_rise));
  // The command bit is held one cycle, so the capture pulse follows the write by one edge
  assign soft_capture = tacho_reg[`TPWM_B_CAPT_SRC] & tacho_reg[`TPWM_B_SOFT_CAPT];
  assign capture_now = hw_capture | soft_capture;
  assign one_shot_stop = tacho_reg[`TPWM_B_ONE_SHOT] & (capture_now | tacho_ovf_i);

  // Level sensitive: the pending bit re-sets every cycle while the pin is active
  assign emerg_active = (emerg_sync == pol_reg[`TPWM_B_EMG_LEVEL]);
  assign emerg_event = tacho_reg[`TPWM_B_EMG_IRQ_EN] & emerg_active;

  assign soft_xfer = xfer_reg[`TPWM_B_XFER_MODE] & xfer_reg[`TPWM_B_SOFT_XFER];

  // ---------------------------------------------------------------
  // Interrupt sources
  // ---------------------------------------------------------------
  assign dir_ok = ~ctrl0_reg[`TPWM_B_SHAPE] |
    (count_up_i ^ pol_reg[`TPWM_B_CMP_DIR]);
  assign set_vec = imask_reg & {cmp0_hit_i, capture_now, tacho_ovf_i, auto_xfer_i,
    pwm_zero_hit_i, phase_cmp_hit_i & {3{dir_ok}}};

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always @*
  begin
    ctrl0_next = ctrl0_reg;
    if (wr_ctrl0)
      ctrl0_next = reg_wdata_i & 8'hFD;
    else
      ctrl0_next = ctrl0_reg & 8'hE7;
    // Software write in the same cycle keeps its own value
    if (one_shot_stop && !wr_ctrl0)
      ctrl0_next[`TPWM_B_TACHO_RUN] = 1'b0;
    ctrl0_next[`TPWM_B_DIR] = 1'b0;

    tacho_next = tacho_reg;
    if (wr_tacho)
      tacho_next = reg_wdata_i & 8'h7F;
    else
      tacho_next[`TPWM_B_SOFT_CAPT] = 1'b0;

    xfer_next = xfer_reg;
    if (wr_xfer)
      xfer_next = reg_wdata_i;
    else
      xfer_next[`TPWM_B_SOFT_XFER] = 1'b0;

    out_next = out_reg;
    if (wr_out)
    begin
      out_next = reg_wdata_i;
      if (emerg_pend_reg)
        out_next[`TPWM_B_OUT_EN] = 1'b0;
    end
    if (emerg_event)
      out_next[`TPWM_B_OUT_EN] = 1'b0;

    // Clear by mask: written zeros clear, ones keep; a new event wins
    pend_next = pend_reg;
    if (wr_pend)
      pend_next = pend_reg & reg_wdata_i;
    pend_next = pend_next | set_vec;

    emerg_pend_next = emerg_pend_reg;
    if (wr_vect && !reg_wdata_i[`TPWM_B_EMG_PEND] && !emerg_active)
      emerg_pend_next = 1'b0;
    if (emerg_event)
      emerg_pend_next = 1'b1;

    rdata_next = 8'h00;
    case (reg_addr_i)
      `TPWM_OFS_CTRL0:
      begin
        rdata_next = ctrl0_reg;
        rdata_next[`TPWM_B_DIR] = count_up_i;
      end
      `TPWM_OFS_TACHO: rdata_next = tacho_reg;
      `TPWM_OFS_XFER: rdata_next = xfer_reg;
      `TPWM_OFS_POL: rdata_next = pol_reg;
      `TPWM_OFS_OUT: rdata_next = out_reg;
      `TPWM_OFS_IMASK: rdata_next = imask_reg;
      `TPWM_OFS_DEAD: rdata_next = {2'b00, dead_reg};
      `TPWM_OFS_PENDING: rdata_next = pend_reg;
      `TPWM_OFS_VECT: rdata_next = {4'h0, emerg_pend_reg, 3'h0};
      default: rdata_next = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ctrl0_reg <= `TPWM_RST_CTRL0 & 8'hFD;
      tacho_reg <= `TPWM_RST_ZERO;
      xfer_reg <= `TPWM_RST_ZERO;
      pol_reg <= `TPWM_RST_ZERO;
      out_reg <= `TPWM_RST_ZERO;
      imask_reg <= `TPWM_RST_ZERO;
      dead_reg <= `TPWM_RST_DEAD;
      pend_reg <= `TPWM_RST_ZERO;
      emerg_pend_reg <= 1'b0;
      rdata_reg <= 8'h00;
      tacho_prev_reg <= 1'b0;
      tacho_clear_reg <= 1'b0;
      capture_reg <= 1'b0;
      load_reg <= 5'h00;
    end
    else
    begin
      ctrl0_reg <= ctrl0_next;
      tacho_reg <= tacho_next;
      xfer_reg <= xfer_next;
      out_reg <= out_next;
      pend_reg <= pend_next;
      emerg_pend_reg <= emerg_pend_next;
      tacho_prev_reg <= tacho_sync;
      capture_reg <= capture_now;
      tacho_clear_reg <= capture_now & tacho_reg[`TPWM_B_CLR_CAPT];
      load_reg <= xfer_reg[6:2] & {5{soft_xfer}};
      if (reg_rd_i)
        rdata_reg <= rdata_next;
      if (reg_wr_i && reg_addr_i == `TPWM_OFS_POL)
        pol_reg <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `TPWM_OFS_IMASK)
        imask_reg <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `TPWM_OFS_DEAD)
        dead_reg <= reg_wdata_i[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Dead time and phase outputs
  // ---------------------------------------------------------------
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph = ph + 1)
    begin : g_phase
      tpwm_dead_time u_dt
      (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .enable_i(ctrl0_reg[`TPWM_B_DT_EN]),
        .delay_i({dead_reg, 1'b0}),
        .ref_i(phase_ref_i[ph]),
        .hi_o(dt_hi[ph]),
        .lo_o(dt_lo[ph])
      );
      // Phase index 2 is U and lands on the top pair of bits
      assign dt_pair[2 * ph + 1] = ctrl0_reg[`TPWM_B_COMPL] ? dt_hi[ph] : phase_ref_i[ph];
      assign dt_pair[2 * ph] = ctrl0_reg[`TPWM_B_COMPL] ? dt_lo[ph] : phase_ref_i[ph];
    end
  endgenerate

  assign src_data = out_reg[`TPWM_B_OUT_SRC] ? out_reg[5:0] : dt_pair;
  assign pol_data = src_data ^ pol_reg[5:0];

  // Outputs are registered so the pins never glitch on a mode change
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      phase_reg <= 6'h00;
      oe_reg <= 6'h00;
    end
    else
    begin
      phase_reg <= pol_data;
      oe_reg <= {6{out_next[`TPWM_B_OUT_EN]}};
    end
  end

  // ---------------------------------------------------------------
  // Output assignments
  // ---------------------------------------------------------------
  assign reg_rdata_o = rdata_reg;
  assign pwm_run_o = ctrl0_reg[`TPWM_B_PWM_RUN];
  assign tacho_run_o = ctrl0_reg[`TPWM_B_TACHO_RUN];
  assign pwm_clear_o = ctrl0_reg[`TPWM_B_PWM_ZERO];
  assign tacho_clear_o = ctrl0_reg[`TPWM_B_TACHO_ZERO] | tacho_clear_reg;
  assign counter_shape_o = ctrl0_reg[`TPWM_B_SHAPE];
  assign tacho_capture_o = capture_reg;
  assign hw_transfer_mode_o = ~xfer_reg[`TPWM_B_XFER_MODE];
  assign soft_load_o = load_reg;
  assign irq_o = xfer_reg[`TPWM_B_GIE] & (|pend_reg);
  assign emerg_core_o = tacho_reg[`TPWM_B_EMG_IRQ_EN] ? emerg_pend_reg : emerg_sync;
  assign phase_out_o = phase_reg;
  assign phase_oe_o = oe_reg;
endmodule

// *** verif/tpwm_chk.sv ***
// Concurrent checks on the ports of the PWM control register block
`timescale 1ns/1ps
module tpwm_chk
(
  input wire core_clk_i,
  input wire srst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire count_up_i,
  input wire pwm_run_o,
  input wire tacho_run_o,
  input wire pwm_clear_o,
  input wire tacho_clear_o,
  input wire counter_shape_o,
  input wire tacho_capture_o,
  input wire hw_transfer_mode_o,
  input wire [4:0] soft_load_o,
  input wire irq_o,
  input wire [5:0] phase_oe_o
);
  // ------
  // Decodes
  // ------
  wire wc0 = reg_wr_i && reg_addr_i == 8'hF8;
  wire wxf = reg_wr_i && reg_addr_i == 8'hFA;
  wire wim = reg_wr_i && reg_addr_i == 8'hFD;
  // Enables kept so a late load pulse is still judged against its own write
  logic [4:0] en_reg;
  always @(posedge core_clk_i)
  begin
    if (srst_i)
      en_reg <= 5'h00;
    else if (wxf)
      en_reg <= reg_wdata_i[6:2];
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ------
  // Assertions
  // ------
  chk_zero_pulse: assert property (wc0 && reg_wdata_i[3] |-> ##[1:2] pwm_clear_o)
    else $error("pwm clear pulse missing");
  chk_zero_single: assert property (pwm_clear_o |=> !pwm_clear_o)
    else $error("pwm clear held too long");
  chk_pwm_run: assert property (wc0 |=> pwm_run_o == $past(reg_wdata_i[5]))
    else $error("pwm run does not follow write");
  chk_tacho_run: assert property (wc0 |=> tacho_run_o == $past(reg_wdata_i[6]))
    else $error("tacho run does not follow write");
  chk_shape_sel: assert property (wc0 |=> counter_shape_o == $past(reg_wdata_i[2]))
    else $error("counter shape does not follow write");
  chk_xfer_mode: assert property (wxf |=> hw_transfer_mode_o == !$past(reg_wdata_i[0]))
    else $error("transfer mode wrong");
  chk_soft_load: assert property (wxf && reg_wdata_i[1:0] == 2'b11 |-> ##[1:3] soft_load_o == en_reg)
    else $error("soft load set wrong");
  chk_hw_noload: assert property (wxf && reg_wdata_i[1:0] == 2'b10 |-> ##1 (soft_load_o == 5'h00) [*3])
    else $error("soft load in hardware mode");
  chk_dir_read: assert property (reg_rd_i && reg_addr_i == 8'hF8 |=> reg_rdata_o[1] == $past(count_up_i))
    else $error("direction flag not live");
  chk_imask_rw: assert property (wim ##2 (reg_rd_i && reg_addr_i == 8'hFD) |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("mask readback wrong");
  chk_oe_group: assert property (phase_oe_o == 6'h00 || phase_oe_o == 6'h3F)
    else $error("phase enables split");
  chk_capt_pulse: assert property (tacho_capture_o |=> !tacho_capture_o)
    else $error("capture pulse too long");
  cover property (pwm_clear_o);
  cover property (soft_load_o != 5'h00);
  cover property (tacho_capture_o && tacho_clear_o);
  cover property (irq_o);
endmodule
bind tpwm_ctrl tpwm_chk chk
(
  .core_clk_i(core_clk_i),
  .srst_i(srst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .count_up_i(count_up_i),
  .pwm_run_o(pwm_run_o),
  .tacho_run_o(tacho_run_o),
  .pwm_clear_o(pwm_clear_o),
  .tacho_clear_o(tacho_clear_o),
  .counter_shape_o(counter_shape_o),
  .tacho_capture_o(tacho_capture_o),
  .hw_transfer_mode_o(hw_transfer_mode_o),
  .soft_load_o(soft_load_o),
  .irq_o(irq_o),
  .phase_oe_o(phase_oe_o)
);

// *** verif/tpwm_gate_model.sv ***
// Behavioural gate driver bank and emergency-stop source
`timescale 1ns/1ps
module tpwm_gate_model
(
  input wire core_clk_i,
  input wire [5:0] phase_out_i,
  input wire [5:0] phase_oe_i,
  input wire estop_req_i,
  output wire emerg_pin_o,
  output logic [5:0] gate_o
);
  // No pulls on the phases, so a floating line shows a changing level
  logic [5:0] last_reg = 6'h00;
  always @(posedge core_clk_i)
  begin
    last_reg <= gate_o;
  end
  always_comb
  begin
    gate_o = (phase_out_i & phase_oe_i) | (~last_reg & ~phase_oe_i);
  end
  assign emerg_pin_o = estop_req_i;
endmodule

// *** verif/tpwm_ctrl_tb.sv ***
// Self-checking bench for the PWM control register block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAIT(c) for (i = 0; i < 8 && !(c); i++) idle(1);
module tpwm_ctrl_tb;
  logic core_clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, count_up_i = 1'b1;
  logic cmp0_hit_i = 1'b0, tacho_ovf_i = 1'b0, auto_xfer_i = 1'b0, pwm_zero_hit_i = 1'b0;
  logic tacho_pin_i = 1'b0, estop = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rv;
  logic [2:0] phase_ref_i = 3'h0, phase_cmp_hit_i = 3'h0;
  wire emerg_pin_i, pwm_run_o, tacho_run_o, pwm_clear_o, tacho_clear_o, counter_shape_o;
  wire tacho_capture_o, hw_transfer_mode_o, irq_o, emerg_core_o;
  wire [7:0] reg_rdata_o;
  wire [4:0] soft_load_o;
  wire [5:0] phase_out_o, phase_oe_o, gate;
  int miscompares = 0, samples_checked = 0, ncap = 0, i, j;
  logic [7:0] ra [8] = '{8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'h10};
  logic [7:0] re [8] = '{8'h83, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h00};
  logic [4:0] sl [3] = '{5'h15, 5'h0A, 5'h1F};
  tpwm_ctrl uut
  (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .count_up_i(count_up_i),
    .phase_ref_i(phase_ref_i),
    .cmp0_hit_i(cmp0_hit_i),
    .tacho_ovf_i(tacho_ovf_i),
    .auto_xfer_i(auto_xfer_i),
    .pwm_zero_hit_i(pwm_zero_hit_i),
    .phase_cmp_hit_i(phase_cmp_hit_i),
    .tacho_pin_i(tacho_pin_i),
    .emerg_pin_i(emerg_pin_i),
    .pwm_run_o(pwm_run_o),
    .tacho_run_o(tacho_run_o),
    .pwm_clear_o(pwm_clear_o),
    .tacho_clear_o(tacho_clear_o),
    .counter_shape_o(counter_shape_o),
    .tacho_capture_o(tacho_capture_o),
    .hw_transfer_mode_o(hw_transfer_mode_o),
    .soft_load_o(soft_load_o),
    .irq_o(irq_o),
    .emerg_core_o(emerg_core_o),
    .phase_out_o(phase_out_o),
    .phase_oe_o(phase_oe_o)
  );
  tpwm_gate_model pm (.core_clk_i(core_clk_i), .phase_out_i(phase_out_o),
    .phase_oe_i(phase_oe_o), .estop_req_i(estop), .emerg_pin_o(emerg_pin_i), .gate_o(gate));
  initial
  begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    if (tacho_capture_o === 1'b1)
      ncap++;
  end
  // ------
  // Tasks
  // ------
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    idle(1);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    idle(1);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    idle(1);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    idle(1);
    reg_rd_i = 1'b0;
    rv = reg_rdata_o;
  endtask
  task automatic ovf;
    idle(1);
    tacho_ovf_i = 1'b1;
    idle(1);
    tacho_ovf_i = 1'b0;
  endtask
  // One-cycle pulse on the counter event inputs: cmp0, transfer, zero, U, V, W
  task automatic hit(input logic [5:0] m);
    idle(1);
    {cmp0_hit_i, auto_xfer_i, pwm_zero_hit_i, phase_cmp_hit_i} = m;
    idle(1);
    {cmp0_hit_i, auto_xfer_i, pwm_zero_hit_i, phase_cmp_hit_i} = 6'h00;
  endtask
  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Whole sequence needs well under a thousand cycles
  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end
  // ------
  // Tests
  // ------
  initial
  begin
    idle(4);
    srst_i = 1'b0;
    for (j = 0; j < 8; j++)
    begin
      rd(ra[j]);
      `CHK(rv, re[j])
    end
    count_up_i = 1'b0;
    wr(8'hF8, 8'h02);
    rd(8'hF8);
    `CHK(rv, 8'h00)
    count_up_i = 1'b1;
    wr(8'hF8, 8'h2C);
    `WAIT(pwm_clear_o)
    `CHK(pwm_clear_o, 1'b1)
    `CHK(pwm_run_o, 1'b1)
    `CHK(counter_shape_o, 1'b1)
    rd(8'hF8);
    `CHK(rv, 8'h26)
    for (j = 0; j < 3; j++)
    begin
      wr(8'hFA, {1'b0, sl[j], 2'b11});
      `WAIT(soft_load_o != 5'h00)
      `CHK(soft_load_o, sl[j])
      rd(8'hFA);
      `CHK(rv, {1'b0, sl[j], 2'b01})
    end
    `CHK(hw_transfer_mode_o, 1'b0)
    wr(8'hFA, 8'h7E);
    `WAIT(soft_load_o != 5'h00)
    `CHK(soft_load_o, 5'h00)
    `CHK(hw_transfer_mode_o, 1'b1)
    wr(8'hF8, 8'h40);
    `CHK(tacho_run_o, 1'b1)
    for (j = 0; j < 4; j++)
    begin
      wr(8'hF9, j[7:0]);
      ncap = 0;
      tacho_pin_i = 1'b1;
      idle(6);
      tacho_pin_i = 1'b0;
      idle(6);
      `CHK(ncap, $countones(j[1:0]))
    end
    wr(8'hF9, 8'h3C);
    `WAIT(tacho_capture_o)
    `CHK(tacho_capture_o, 1'b1)
    `CHK(tacho_clear_o, 1'b1)
    idle(2);
    `CHK(tacho_run_o, 1'b0)
    rd(8'hF9);
    `CHK(rv, 8'h34)
    wr(8'hFD, 8'h20);
    rd(8'hFD);
    `CHK(rv, 8'h20)
    ovf();
    idle(2);
    `CHK(irq_o, 1'b0)
    rd(8'hF3);
    `CHK(rv, 8'h20)
    wr(8'hFA, 8'h80);
    idle(1);
    `CHK(irq_o, 1'b1)
    wr(8'hF3, 8'hFF);
    rd(8'hF3);
    `CHK(rv, 8'h20)
    wr(8'hF3, 8'hDF);
    rd(8'hF3);
    `CHK(rv, 8'h00)
    `CHK(irq_o, 1'b0)
    wr(8'hFD, 8'h00);
    ovf();
    idle(2);
    rd(8'hF3);
    `CHK(rv, 8'h00)
    wr(8'hF8, 8'h04);
    wr(8'hFD, 8'h9F);
    count_up_i = 1'b0;
    hit(6'h3F);
    rd(8'hF3);
    `CHK(rv, 8'h98)
    count_up_i = 1'b1;
    hit(6'h05);
    wr(8'hFB, 8'h40);
    count_up_i = 1'b0;
    hit(6'h02);
    rd(8'hF3);
    `CHK(rv, 8'h9F)
    `CHK(irq_o, 1'b1)
    wr(8'hF3, 8'h00);
    wr(8'hFD, 8'h00);
    count_up_i = 1'b1;
    wr(8'hFB, 8'h15);
    wr(8'hFC, 8'hF3);
    idle(3);
    `CHK(phase_oe_o, 6'h3F)
    `CHK(gate, 6'h26)
    wr(8'hF8, 8'h00);
    phase_ref_i = 3'b011;
    wr(8'hFC, 8'h80);
    idle(4);
    `CHK(gate, 6'h1A)
    wr(8'hFE, 8'h02);
    wr(8'hF8, 8'h81);
    idle(2);
    `CHK(gate, 6'h0F)
    phase_ref_i = 3'b111;
    idle(2);
    `CHK(gate, 6'h1F)
    idle(5);
    `CHK(gate, 6'h3F)
    wr(8'hF8, 8'h01);
    phase_ref_i = 3'b011;
    idle(2);
    `CHK(gate, 6'h0F)
    wr(8'hFC, 8'h00);
    idle(2);
    `CHK(phase_oe_o, 6'h00)
    estop = 1'b1;
    idle(4);
    `CHK(emerg_core_o, 1'b1)
    estop = 1'b0;
    idle(4);
    `CHK(emerg_core_o, 1'b0)
    wr(8'hFB, 8'h95);
    wr(8'hF9, 8'h40);
    wr(8'hFC, 8'h80);
    idle(2);
    `CHK(phase_oe_o, 6'h3F)
    estop = 1'b1;
    `WAIT(phase_oe_o == 6'h00)
    `CHK(phase_oe_o, 6'h00)
    `CHK(emerg_core_o, 1'b1)
    wr(8'hFC, 8'h80);
    idle(2);
    `CHK(phase_oe_o, 6'h00)
    wr(8'hFF, 8'h00);
    rd(8'hFF);
    `CHK(rv[3], 1'b1)
    estop = 1'b0;
    idle(4);
    `CHK(emerg_core_o, 1'b1)
    wr(8'hFF, 8'h00);
    rd(8'hFF);
    `CHK(rv[3], 1'b0)
    wr(8'hFC, 8'h80);
    idle(2);
    `CHK(phase_oe_o, 6'h3F)
    wr(8'hFB, 8'h15);
    `WAIT(phase_oe_o == 6'h00)
    `CHK(emerg_core_o, 1'b1)
    end_sim();
  end
endmodule
